//--- core/afe_pins.sv
// Pin-level digital interface: ready pulse, clock select, serial port,
// hard reset, interface mode and two-wire strap latching.
// Assumes all pins are synchronous to CLOCK, the master clock.
`timescale 1ns/1ns
`default_nettype none
module afe_pins (
	// Clock and power-on reset
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic WDT_RESET,
	// Configuration
	input wire logic READY_PIN_TRISTATE_SEL,
	input wire logic EXTERNAL_CLOCK_SEL,
	input wire logic [1:0] CLOCK_PRESCALE_SEL,
	input wire logic [2:0] OVERSAMPLING_RATIO_SEL,
	// Conversion-ready pin, two-way
	input wire logic CONVERSION_READY_N_I,
	output logic CONVERSION_READY_N_O,
	output logic CONVERSION_READY_N_OE,
	// Crystal pins as logic inputs
	input wire logic CRYSTAL_PIN_A_I,
	input wire logic CRYSTAL_PIN_B_I,
	// Serial pins
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SDI,
	input wire logic RESET_N,
	output logic SDO_O,
	output logic SDO_OE,
	// Command and read data
	output logic CMD_VALID,
	output logic [7:0] CMD_BYTE,
	output logic RD_REQ,
	input wire logic [7:0] RD_DATA,
	// Clock tree and status
	output logic OSC_ENABLE,
	output logic CLOCK_RUN,
	output logic ANALOG_BIAS_EN,
	output logic ANALOG_MASTER_CLOCK_EN,
	output logic DIGITAL_SAMPLE_CLOCK_EN,
	output logic OUTPUT_RATE_CLOCK_EN,
	output logic TWO_WIRE_MODE,
	output afe_pkg::afe_strap_s STRAPS
);
	logic mode_q;
	logic mode_d;
	logic latch_q;
	logic hard_rst;
	logic run_n;
	logic strap_load;
	afe_pkg::afe_strap_s strap_q;
	afe_pkg::afe_strap_s strap_pins;
	afe_pkg::afe_clk_s clk_s;
	afe_pkg::afe_spi_e state_q;
	afe_pkg::afe_spi_e state_d;
	logic active;
	logic sck_q;
	logic sck_rise;
	logic sck_fall;
	logic [2:0] bit_cnt_q;
	logic [7:0] cmd_sr_q;
	logic [7:0] cmd_byte_q;
	logic cmd_valid_q;
	logic cmd_done;
	logic [7:0] out_sr_q;
	logic sdo_q;
	logic read_shift;

	// Hard reset only exists while the reset pin is a reset, not a strap
	assign hard_rst = mode_q == afe_pkg::MODE_SPI && !RESET_N;
	assign run_n = NRST && !hard_rst;
	assign CLOCK_RUN = run_n;
	assign ANALOG_BIAS_EN = 1'b1;
	assign OSC_ENABLE = !EXTERNAL_CLOCK_SEL;

	// Mode pin only means anything with the external clock chosen
	assign mode_d = latch_q ? EXTERNAL_CLOCK_SEL && CRYSTAL_PIN_B_I : mode_q;
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			mode_q <= afe_pkg::MODE_SPI;
			latch_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			latch_q <= hard_rst || WDT_RESET;
		end
	end
	assign TWO_WIRE_MODE = mode_q;

	assign strap_pins = '{gain_select_hi: CONVERSION_READY_N_I,
		gain_select_lo: CRYSTAL_PIN_A_I, bias_boost_sel: CS_N,
		ratio_select_hi: SDI, ratio_select_lo: RESET_N};
	assign strap_load = mode_d && (!mode_q || WDT_RESET);
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			strap_q <= '0;
		else if (strap_load)
			strap_q <= strap_pins;
	end
	assign STRAPS = strap_q;

	afe_clkdiv u_div (
		.clk(CLOCK),
		.run_n(run_n),
		.pre_sel(CLOCK_PRESCALE_SEL),
		.osr_sel(OVERSAMPLING_RATIO_SEL),
		.clk_o(clk_s)
	);
	assign ANALOG_MASTER_CLOCK_EN = clk_s.analog_master_clock_en;
	assign DIGITAL_SAMPLE_CLOCK_EN = clk_s.digital_sample_clock_en;
	assign OUTPUT_RATE_CLOCK_EN = clk_s.output_rate_clock_en;

	// Pin turns input in two-wire mode; drive low only during the pulse
	assign CONVERSION_READY_N_O = clk_s.ready_n;
	assign CONVERSION_READY_N_OE = mode_q == afe_pkg::MODE_SPI &&
		(READY_PIN_TRISTATE_SEL || !clk_s.ready_n);

	// Serial port, SCK oversampled by the master clock
	assign active = !CS_N && mode_q == afe_pkg::MODE_SPI && run_n;
	assign sck_rise = SCK && !sck_q;
	assign sck_fall = !SCK && sck_q;
	assign cmd_done = state_q == afe_pkg::ST_CMD && sck_rise && bit_cnt_q == 3'h7;
	assign read_shift = state_q == afe_pkg::ST_READ && sck_fall;
	assign RD_REQ = read_shift && bit_cnt_q == 3'h0;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			afe_pkg::ST_IDLE: state_d = afe_pkg::ST_CMD;
			afe_pkg::ST_CMD: begin
				if (cmd_done)
					state_d = SDI_read_sel(cmd_sr_q) ? afe_pkg::ST_READ : afe_pkg::ST_WRITE;
			end
			afe_pkg::ST_READ: state_d = afe_pkg::ST_READ;
			afe_pkg::ST_WRITE: state_d = afe_pkg::ST_WRITE;
		endcase
		if (!active)
			state_d = afe_pkg::ST_IDLE;
	end

	function automatic logic SDI_read_sel(input logic [7:0] sr);
		logic [7:0] cmd;
		cmd = {sr[6:0], SDI};
		return cmd[afe_pkg::CMD_READ_BIT];
	endfunction

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state_q <= afe_pkg::ST_IDLE;
			sck_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sck_q <= SCK;
		end
	end

	// Bit counter shared by command and read phases
	always_ff @(posedge CLOCK) begin
		if (!NRST || state_q == afe_pkg::ST_IDLE || cmd_done)
			bit_cnt_q <= 3'h0;
		else if ((state_q == afe_pkg::ST_CMD && sck_rise) || read_shift)
			bit_cnt_q <= bit_cnt_q + 3'h1;
	end

	// Command shift only; data input ignored in later phases
	always_ff @(posedge CLOCK) begin
		if (!NRST || state_q == afe_pkg::ST_IDLE)
			cmd_sr_q <= 8'h00;
		else if (state_q == afe_pkg::ST_CMD && sck_rise)
			cmd_sr_q <= {cmd_sr_q[6:0], SDI};
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			cmd_valid_q <= 1'b0;
			cmd_byte_q <= 8'h00;
		end else begin
			cmd_valid_q <= cmd_done && active;
			if (cmd_done && active)
				cmd_byte_q <= {cmd_sr_q[6:0], SDI};
		end
	end
	assign CMD_VALID = cmd_valid_q;
	assign CMD_BYTE = cmd_byte_q;

	// Byte reload every eight falling edges keeps reads streaming
	always_ff @(posedge CLOCK) begin
		if (!NRST || state_q != afe_pkg::ST_READ) begin
			out_sr_q <= 8'h00;
			sdo_q <= 1'b0;
		end else if (RD_REQ) begin
			sdo_q <= RD_DATA[7];
			out_sr_q <= {RD_DATA[6:0], 1'b0};
		end else if (read_shift) begin
			sdo_q <= out_sr_q[7];
			out_sr_q <= {out_sr_q[6:0], 1'b0};
		end
	end
	assign SDO_O = sdo_q;
	assign SDO_OE = state_q == afe_pkg::ST_READ && active;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	a_ready_idle: assert property (
		mode_q == afe_pkg::MODE_SPI && clk_s.ready_n |->
		CONVERSION_READY_N_OE == READY_PIN_TRISTATE_SEL && CONVERSION_READY_N_O)
		else $error("idle ready pin drive wrong");
	a_ready_pulse: assert property (
		clk_s.output_rate_clock_en && mode_q == afe_pkg::MODE_SPI && run_n ##1 run_n |->
		CONVERSION_READY_N_OE && !CONVERSION_READY_N_O)
		else $error("no ready pulse after conversion");
	a_osc_select: assert property (
		EXTERNAL_CLOCK_SEL |-> !OSC_ENABLE)
		else $error("oscillator left on with external clock");
	a_mode_latch: assert property (
		WDT_RESET && !EXTERNAL_CLOCK_SEL |=> ##1 mode_q == afe_pkg::MODE_SPI)
		else $error("mode not relatched to serial port");
	a_strap_hold: assert property (
		$rose(mode_q) |-> STRAPS == $past(strap_pins))
		else $error("straps not taken on mode entry");
	a_reset_block: assert property (
		hard_rst |-> ##[0:2] state_q == afe_pkg::ST_IDLE && !CMD_VALID && !SDO_OE)
		else $error("serial traffic during hard reset");
	a_sdo_quiet: assert property (
		state_q == afe_pkg::ST_CMD || state_q == afe_pkg::ST_WRITE || CS_N |-> !SDO_OE)
		else $error("data out driven outside read");
	a_cmd_frame: assert property (
		CMD_VALID |-> $past(state_q) == afe_pkg::ST_CMD && $past(bit_cnt_q) == 3'h7)
		else $error("command not eight bits");
	a_run_stop: assert property (
		hard_rst [*2] |-> !ANALOG_MASTER_CLOCK_EN && CONVERSION_READY_N_O)
		else $error("clock distributed during hard reset");
	a_bias_on: assert property (
		hard_rst |-> ANALOG_BIAS_EN)
		else $error("bias dropped in reset");
	// Straps move only on mode entry or a watchdog event
	a_strap_still: assert property (
		mode_q && $past(mode_q) && !$past(WDT_RESET) |-> $stable(STRAPS))
		else $error("straps changed without a relatch");
	a_sdi_ignored: assert property (
		state_q == afe_pkg::ST_READ || state_q == afe_pkg::ST_WRITE |=> !CMD_VALID)
		else $error("second command taken in one frame");
	a_osc_on: assert property (
		!EXTERNAL_CLOCK_SEL |-> OSC_ENABLE)
		else $error("oscillator off with crystal chosen");
	a_two_wire_float: assert property (
		TWO_WIRE_MODE |-> !CONVERSION_READY_N_OE && !SDO_OE)
		else $error("pin driven while used as strap input");
	// Crystal in use means the mode pin is a crystal pin, not a select
	a_mode_spi: assert property (
		latch_q && !EXTERNAL_CLOCK_SEL |=> mode_q == afe_pkg::MODE_SPI)
		else $error("two-wire mode taken with crystal chosen");

	c_read: cover property (CMD_VALID && state_q == afe_pkg::ST_READ ##[1:40] RD_REQ);
	c_write: cover property (CMD_VALID && state_q == afe_pkg::ST_WRITE);
	c_pulse: cover property ($rose(CONVERSION_READY_N_O) && CONVERSION_READY_N_OE);
	c_two_wire: cover property ($rose(TWO_WIRE_MODE));
	c_hard_reset: cover property (hard_rst ##1 !hard_rst);
endmodule // afe_pins
`default_nettype wire

//--- core/afe_pkg.sv
// Shared constants, types and helpers of the front-end digital pin block.
// Assumes a single master clock; all slower rates are enable pulses.
package afe_pkg;
	// Prescale select codes, divide by 1, 2, 4, 8
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV2 = 2'h1;
	localparam logic [1:0] PRE_DIV4 = 2'h2;
	localparam logic [1:0] PRE_DIV8 = 2'h3;
	localparam logic [1:0] PRE_RESET = PRE_DIV1;
	// Ratio select: code 0 is 32, each step doubles, default 256
	localparam logic [2:0] OSR_RESET = 3'h3;
	localparam logic [12:0] OSR_MIN = 13'h0020;
	// Analog clock edges per sample clock, and ready low span
	localparam int DIGITAL_SAMPLE_CLOCK_DIV = 4;
	localparam int READY_LOW_ANALOG_MASTER_CLOCK = DIGITAL_SAMPLE_CLOCK_DIV / 2;
	// Command framing
	localparam int CMD_BITS = 8;
	localparam int CMD_READ_BIT = 0;
	localparam logic MODE_SPI = 1'b0;
	localparam logic MODE_TWO_WIRE = 1'b1;

	typedef struct packed {
		logic gain_select_hi;
		logic gain_select_lo;
		logic bias_boost_sel;
		logic ratio_select_hi;
		logic ratio_select_lo;
	} afe_strap_s;

	typedef struct packed {
		logic analog_master_clock_en;
		logic digital_sample_clock_en;
		logic output_rate_clock_en;
		logic ready_n;
	} afe_clk_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_READ = 2'b10,
		ST_WRITE = 2'b11
	} afe_spi_e;

	function automatic logic [3:0] pre_div(input logic [1:0] code);
		return 4'h1 << code;
	endfunction

	function automatic logic [12:0] osr_val(input logic [2:0] code);
		return OSR_MIN << code;
	endfunction
endpackage

//--- core/afe_clkdiv.sv
// Prescaler, sample clock and output rate dividers with ready pulse.
// Assumes pre_sel and osr_sel change only between frames of interest.
`timescale 1ns/1ns
`default_nettype none
module afe_clkdiv (
	// Clock and synchronous reset, low also stops distribution
	input wire logic clk,
	input wire logic run_n,
	// Rate selection
	input wire logic [1:0] pre_sel,
	input wire logic [2:0] osr_sel,
	// Enables and ready pulse
	output afe_pkg::afe_clk_s clk_o
);
	logic [3:0] div;
	logic [12:0] oversampling_ratio;
	logic [3:0] pre_cnt_q;
	logic [1:0] quarter_q;
	logic [12:0] osr_cnt_q;
	logic ready_n_q;
	logic analog_master_clock_en;
	logic digital_sample_clock_en;
	logic output_rate_clock_en;
	logic ready_end;

	assign div = afe_pkg::pre_div(pre_sel);
	assign oversampling_ratio = afe_pkg::osr_val(osr_sel);
	// Compare with >= so a smaller divide picked mid-count cannot hang
	// Gated by run so no enable escapes while distribution is stopped
	assign analog_master_clock_en = run_n && pre_cnt_q >= div - 4'h1;
	assign digital_sample_clock_en = analog_master_clock_en && quarter_q == 2'(afe_pkg::DIGITAL_SAMPLE_CLOCK_DIV - 1);
	assign output_rate_clock_en = digital_sample_clock_en && osr_cnt_q >= oversampling_ratio - 13'h0001;
	assign ready_end = analog_master_clock_en && osr_cnt_q == 13'h0000 &&
		quarter_q == 2'(afe_pkg::READY_LOW_ANALOG_MASTER_CLOCK - 1);

	always_ff @(posedge clk) begin
		if (!run_n || analog_master_clock_en)
			pre_cnt_q <= 4'h0;
		else
			pre_cnt_q <= pre_cnt_q + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (!run_n)
			quarter_q <= 2'h0;
		else if (analog_master_clock_en)
			quarter_q <= quarter_q + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (!run_n || output_rate_clock_en)
			osr_cnt_q <= 13'h0000;
		else if (digital_sample_clock_en)
			osr_cnt_q <= osr_cnt_q + 13'h0001;
	end

	// Low for the first half sample period of each output period
	always_ff @(posedge clk) begin
		if (!run_n)
			ready_n_q <= 1'b1;
		else if (output_rate_clock_en)
			ready_n_q <= 1'b0;
		else if (ready_end)
			ready_n_q <= 1'b1;
	end

	assign clk_o = '{analog_master_clock_en: analog_master_clock_en, digital_sample_clock_en: digital_sample_clock_en,
		output_rate_clock_en: output_rate_clock_en, ready_n: ready_n_q};

	logic [6:0] low_len_q;
	always_ff @(posedge clk) begin
		if (!run_n || ready_n_q)
			low_len_q <= 7'h00;
		else
			low_len_q <= low_len_q + 7'h01;
	end

	a_ready_width: assert property (@(posedge clk) disable iff (!run_n)
		$rose(ready_n_q) && $stable(pre_sel) |->
		low_len_q == {3'h0, div} * 7'(afe_pkg::READY_LOW_ANALOG_MASTER_CLOCK))
		else $error("ready low span is not half a sample period");
	a_ready_rate: assert property (@(posedge clk) disable iff (!run_n)
		$fell(ready_n_q) |-> $past(output_rate_clock_en))
		else $error("ready pulse started off the output rate tick");
endmodule // afe_clkdiv
`default_nettype wire

//--- sim/afe_host_model.sv
// Host side of the serial port: one mode 0,0 frame per go pulse.
// Assumes clk is the master clock; each SCK phase spans three cycles.
`timescale 1ns/1ns
`default_nettype none
module afe_host_model (
	// Clock and request
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] cmd,
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo,
	// Frame status and read byte
	output logic busy,
	output logic [7:0] rx
);
	int i;
	task automatic half();
		repeat (3) @(posedge clk);
	endtask
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
		busy = 1'b0;
		rx = 8'h00;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				cs_n <= 1'b0;
				half();
				for (i = 0; i < 16; i++) begin
					// Toggling past the command shows it is ignored
					sdi <= (i < 8) ? cmd[7 - i] : ~sdi;
					half();
					sck <= 1'b1;
					if (i >= 8)
						rx <= {rx[6:0], sdo};
					half();
					sck <= 1'b0;
				end
				half();
				cs_n <= 1'b1;
				sdi <= ~sdi;
				busy <= 1'b0;
			end
		end
	end
endmodule // afe_host_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the pin block with a host model.
// Assumes inputs change by NBA at rising edges, sampled at falling.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0, nrst = 1'b0, wdt = 1'b0, tsel = 1'b0, ext = 1'b1, go = 1'b0, rstn = 1'b1, son = 1'b0;
	logic [1:0] pre = 2'h0;
	logic [2:0] oversampling_ratio = 3'h3;
	logic [4:0] st = 5'h00;
	logic xb = 1'b0, sdo_l = 1'b0;
	logic [7:0] hcmd = 8'h00, rdd = 8'ha5;
	int errors = 0, num_checks = 0, oe_cnt = 0, cv_cnt = 0;
	wire logic h_cs, h_sck, h_sdi, h_busy, rdy_o, rdy_oe, sdo_o, sdo_oe, sdo_w, c_v, run, bias, two, osc;
	wire logic [7:0] h_rx, cmd_b;
	afe_pkg::afe_strap_s straps;
	// Undriven line shows the inverse of its last value
	assign sdo_w = sdo_oe ? sdo_o : ~sdo_l;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		oe_cnt <= oe_cnt + int'(sdo_oe);
		cv_cnt <= cv_cnt + int'(c_v);
		if (sdo_oe)
			sdo_l <= sdo_o;
	end
	afe_host_model host_u (.clk(clk), .go(go), .cmd(hcmd), .cs_n(h_cs), .sck(h_sck), .sdi(h_sdi), .sdo(sdo_w),
		.busy(h_busy), .rx(h_rx));
	afe_pins dut_u (.CLOCK(clk), .NRST(nrst), .WDT_RESET(wdt), .READY_PIN_TRISTATE_SEL(tsel),
		.EXTERNAL_CLOCK_SEL(ext), .CLOCK_PRESCALE_SEL(pre), .OVERSAMPLING_RATIO_SEL(oversampling_ratio),
		.CONVERSION_READY_N_I(rdy_oe ? rdy_o : st[4]), .CONVERSION_READY_N_O(rdy_o),
		.CONVERSION_READY_N_OE(rdy_oe), .CRYSTAL_PIN_A_I(st[3]), .CRYSTAL_PIN_B_I(xb),
		.CS_N(son ? st[2] : h_cs), .SCK(h_sck), .SDI(son ? st[1] : h_sdi), .RESET_N(son ? st[0] : rstn),
		.SDO_O(sdo_o), .SDO_OE(sdo_oe), .CMD_VALID(c_v), .CMD_BYTE(cmd_b), .RD_REQ(), .RD_DATA(rdd),
		.OSC_ENABLE(osc), .CLOCK_RUN(run), .ANALOG_BIAS_EN(bias), .ANALOG_MASTER_CLOCK_EN(), .DIGITAL_SAMPLE_CLOCK_EN(), .OUTPUT_RATE_CLOCK_EN(),
		.TWO_WIRE_MODE(two), .STRAPS(straps));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic xfer(input logic [7:0] c, output int oe, output int cv);
		int k;
		oe = oe_cnt;
		cv = cv_cnt;
		@(posedge clk);
		hcmd <= c;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		cyc(2);
		for (k = 0; k < 400 && h_busy; k++)
			cyc(1);
		cyc(3);
		oe = oe_cnt - oe;
		cv = cv_cnt - cv;
	endtask
	task automatic pulse_wdt();
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		cyc(3);
	endtask
	task automatic t_spi();
		int oe, cv;
		xfer(8'h41, oe, cv);
		chk(16'(h_rx), 16'h00a5);
		chk(16'(cmd_b), 16'h0041);
		chk(16'(cv), 16'h0001);
		chk(16'(oe > 40 && oe < 60), 16'h0001);
		chk(16'(sdo_oe), 16'h0000);
		xfer(8'h40, oe, cv);
		chk(16'(cmd_b), 16'h0040);
		chk(16'(oe), 16'h0000);
		@(posedge clk);
		rstn <= 1'b0;
		cyc(2);
		chk(16'(run), 16'h0000);
		chk(16'(rdy_o), 16'h0001);
		xfer(8'h81, oe, cv);
		chk(16'(cv), 16'h0000);
		chk(16'(oe), 16'h0000);
		chk(16'(bias), 16'h0001);
		@(posedge clk);
		rstn <= 1'b1;
		cyc(2);
		xfer(8'h43, oe, cv);
		chk(16'(h_rx), 16'h00a5);
	endtask
	task automatic wait_rdy(input logic v);
		int k;
		for (k = 0; k < 40000 && rdy_o !== v; k++)
			cyc(1);
	endtask
	task automatic t_ready(input logic [1:0] p, input logic [2:0] o);
		int w, h;
		@(posedge clk);
		pre <= p;
		oversampling_ratio <= o;
		tsel <= p[0];
		wait_rdy(1'b0);
		wait_rdy(1'b1);
		chk(16'(rdy_oe), 16'(p[0]));
		for (h = 0; h < 40000 && rdy_o === 1'b1; h++)
			cyc(1);
		for (w = 0; w < 999 && rdy_o === 1'b0; w++)
			cyc(1);
		chk(16'(w), 16'(2 << p));
		chk(16'(w + h), 16'((4 << p) * (32 << o)));
	endtask
	task automatic t_mode();
		@(posedge clk);
		ext <= 1'b0;
		xb <= 1'b1;
		pulse_wdt();
		chk(16'(osc), 16'h0001);
		chk(16'(two), 16'h0000);
		@(posedge clk);
		ext <= 1'b1;
		son <= 1'b1;
		st <= 5'h16;
		pulse_wdt();
		chk(16'(osc), 16'h0000);
		chk(16'(two), 16'h0001);
		chk(16'(straps), 16'h0016);
		chk(16'(rdy_oe), 16'h0000);
		@(posedge clk);
		st <= 5'h09;
		cyc(4);
		chk(16'(straps), 16'h0016);
		pulse_wdt();
		chk(16'(straps), 16'h0009);
		@(posedge clk);
		nrst <= 1'b0;
		cyc(3);
		@(posedge clk);
		nrst <= 1'b1;
		cyc(4);
		chk(16'(two), 16'h0001);
		@(posedge clk);
		xb <= 1'b0;
		pulse_wdt();
		chk(16'(two), 16'h0000);
		@(posedge clk);
		son <= 1'b0;
	endtask
	initial begin
		#950000;
		errors++;
		tally_and_finish();
	end
	initial begin
		int i;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		cyc(3);
		t_spi();
		t_mode();
		for (i = 0; i < 8; i++)
			t_ready((i < 4) ? 2'(i) : 2'h0, 3'(i));
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
